// file: src/dma_ctl_cfg.svh
// Register offsets, field positions, reset values and limits of the DMA request and mode control.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef DMA_CTL_CFG_SVH
`define DMA_CTL_CFG_SVH

// ********************************************************************
// Register offsets on the plain register port
// ********************************************************************
`define OFS_ROUTING 4'h0
`define OFS_MODE 4'h1
`define OFS_WAITCTL 4'h2
`define OFS_SRC_LO 4'h3
`define OFS_SRC_MID 4'h4
`define OFS_SRC_HI 4'h5
`define OFS_DST_LO 4'h6
`define OFS_DST_MID 4'h7
`define OFS_DST_HI 4'h8
`define OFS_MEM1_LO 4'h9
`define OFS_MEM1_MID 4'ha
`define OFS_MEM1_HI 4'hb
`define OFS_STATUS 4'hc

// ********************************************************************
// Field positions
// ********************************************************************
`define RT_ALT_EN 7
`define RT_ALT_FF 6
`define MD_DST_LSB 4
`define MD_SRC_LSB 2
`define MD_BURST 1
`define WC_MWAIT_LSB 6
`define WC_IWAIT_LSB 4
`define WC_CH1_MODE_LSB 0
`define WC_DIR1 1
`define WC_SENSE1 3
`define WC_SENSE0 2

// ********************************************************************
// Reset values and limits
// ********************************************************************
`define RST_ROUTING 8'h00
`define RST_MODE 8'h00
`define RST_WAITCTL 8'hf0
`define IO_WAIT_BASE 3'h1
`define ADDR_W 20

`endif

// file: src/dma_ctl_pkg.sv
// Types shared by the DMA request and mode control.
// Assumes the configuration header sits on the include path.
`include "dma_ctl_cfg.svh"

package dma_ctl_pkg;

   typedef enum logic [1:0] {ADDR_INC, ADDR_DEC, ADDR_FIXED, ADDR_IO} addr_mode_t;
   typedef enum logic [2:0] {RQ_EXT1, RQ_SER0, RQ_SER1, RQ_EXT0, RQ_NONE} req_src_t;
   typedef enum {WAIT_IDLE, WAIT_COUNT} wait_state_t;

endpackage : dma_ctl_pkg

// file: src/req_sense.sv
// One external request input, sensed as a level or as a falling edge.
// Assumes the request pin is active low and synchronous to clk.
module req_sense
   import dma_ctl_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   input wire logic clkEn,
   // Request pin and setup
   input wire logic reqN,
   input wire logic edgeSense,
   input wire logic taken,
   // Request seen by the channels
   output logic req
);

   logic prevReg;
   logic prevNext;
   logic latchReg;
   logic latchNext;

   // [RULE18] edge or level
   always_comb
   begin
      prevNext = reqN;
      latchNext = latchReg;
      if (taken)
      begin
         latchNext = 1'b0;
      end
      if (prevReg && !reqN)
      begin
         latchNext = 1'b1;
      end
      if (!edgeSense)
      begin
         latchNext = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         prevReg <= 1'b1;
         latchReg <= 1'b0;
      end
      else if (clkEn)
      begin
         prevReg <= prevNext;
         latchReg <= latchNext;
      end
   end

   assign req = edgeSense ? latchReg : !reqN;

endmodule : req_sense

// file: src/wait_gen.sv
// Wait-state counter for one DMA bus cycle.
// Assumes start is a one-cycle pulse at the beginning of each bus cycle.
module wait_gen
   import dma_ctl_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   input wire logic clkEn,
   // Cycle request
   input wire logic start,
   input wire logic ioCycle,
   input wire logic [1:0] memWait,
   input wire logic [1:0] ioWait,
   // Wait output
   output logic waitActive
);

   wait_state_t stateReg;
   wait_state_t stateNext;
   logic [2:0] cntReg;
   logic [2:0] cntNext;

   // [RULE15] wait counts
   always_comb
   begin
      stateNext = stateReg;
      cntNext = cntReg;
      case (stateReg)
         WAIT_IDLE:
         begin
            if (start)
            begin
               cntNext = ioCycle ? ({1'b0, ioWait} + `IO_WAIT_BASE) : {1'b0, memWait};
               if (cntNext != 3'h0)
               begin
                  stateNext = WAIT_COUNT;
               end
            end
         end
         WAIT_COUNT:
         begin
            cntNext = cntReg - 3'h1;
            if (cntReg == 3'h1)
            begin
               stateNext = WAIT_IDLE;
            end
         end
         default:
         begin
            stateNext = WAIT_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         stateReg <= WAIT_IDLE;
         cntReg <= 3'h0;
      end
      else if (clkEn)
      begin
         stateReg <= stateNext;
         cntReg <= cntNext;
      end
   end

   assign waitActive = (stateReg == WAIT_COUNT);

endmodule : wait_gen

// file: src/dma_req_mode_ctl.sv
// Request routing, alternation and addressing-mode control for a two-channel DMA.
// Assumes synchronous request inputs and one-cycle transfer-end and byte-done pulses.
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`include "dma_ctl_cfg.svh"

// Overview of operation
// [RULE1] With alternation on, channel 0 end sets the flip-flop; request goes to channel 1.
// [RULE2] Channel 1 end clears the flip-flop; request returns to channel 0 only.
// [RULE3] Alternation enable, bit 7 of routing register, resets to zero.
// [RULE4] Software enables alternation only when both channels share one requester.
// [RULE5] Differing sources with alternation set force channel 0 request onto channel 1.
// [RULE6] Bit 6 picks receiving channel; toggled by channel ends while alternating.
// [RULE7] Software writes zero to reserved routing bits 5 to 3.
// [RULE8] Direction zero: codes 000..011 route line 1, serial 0 tx, serial 1 tx, line 0.
// [RULE9] Direction one: codes 000..011 route line 1, serial 0 rx, serial 1 rx, line 0.
// [RULE10] Software never writes routing codes 100 to 111.
// [RULE11] Channel 0 destination mode: increment, decrement, fixed, fixed I/O.
// [RULE12] Channel 0 source mode: increment, decrement, fixed, fixed I/O.
// [RULE13] Transfer-mode bit zero is cycle steal, one is burst.
// [RULE14] Channel 1 mode picks direction and memory increment or decrement.
// [RULE15] Memory wait 0 to 3 states, I/O wait 1 to 4 states.
// [RULE16] Software zeroes memory wait when chip-select wait generators are used.
// [RULE17] Channel 0 address bits 17 and 16 pick its request source.
// [RULE18] External requests are edge sensed when sense bit is one, else level.
// [RULE19] Each completed byte moves every non-fixed address by one.
module dma_req_mode_ctl
   import dma_ctl_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   input wire logic clkEn,
   // Register port
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   // Requesters
   input wire logic externalRequestLine1N,
   input wire logic sharedClockRequestLine0N,
   input wire logic serial0TxReq,
   input wire logic serial0RxReq,
   input wire logic serial1TxReq,
   input wire logic serial1RxReq,
   // Channel events
   input wire logic chan0TransferEnd,
   input wire logic chan1TransferEnd,
   input wire logic chan0ByteDone,
   input wire logic chan1ByteDone,
   input wire logic busCycleStart,
   input wire logic busCycleIo,
   // Channel outputs
   output logic chan0Req,
   output logic chan1Req,
   output logic chan0Burst,
   output logic chan0SrcIo,
   output logic chan0DstIo,
   output logic chan1IoToMem,
   output logic waitActive,
   output logic [`ADDR_W-1:0] chan0SourcePointer,
   output logic [`ADDR_W-1:0] chan0DestPointer,
   output logic [`ADDR_W-1:0] chan1MemoryPointer
);

   logic [7:0] routingReg;
   logic [7:0] routingNext;
   logic [7:0] modeReg;
   logic [7:0] modeNext;
   logic [7:0] waitCtlReg;
   logic [7:0] waitCtlNext;
   logic [`ADDR_W-1:0] srcReg;
   logic [`ADDR_W-1:0] srcNext;
   logic [`ADDR_W-1:0] dstReg;
   logic [`ADDR_W-1:0] dstNext;
   logic [`ADDR_W-1:0] mem1Reg;
   logic [`ADDR_W-1:0] mem1Next;
   logic [7:0] rdataReg;
   logic [7:0] rdataNext;
   logic ext1Req;
   logic ext0Req;
   logic ch0Raw;
   logic ch1Raw;
   logic [1:0] ch0Sel;
   logic sameSource;
   logic altEn;
   logic altFf;
   addr_mode_t dstMode;
   addr_mode_t srcMode;
   logic [1:0] ch1Mode;

   // ********************************************************************
   // External request sensing
   // ********************************************************************
   req_sense sense1
   (
      .clk(clk),
      .srst(srst),
      .clkEn(clkEn),
      .reqN(externalRequestLine1N),
      .edgeSense(waitCtlReg[`WC_SENSE1]),
      .taken(chan0ByteDone | chan1ByteDone),
      .req(ext1Req)
   );

   req_sense sense0
   (
      .clk(clk),
      .srst(srst),
      .clkEn(clkEn),
      .reqN(sharedClockRequestLine0N),
      .edgeSense(waitCtlReg[`WC_SENSE0]),
      .taken(chan0ByteDone | chan1ByteDone),
      .req(ext0Req)
   );

   // ********************************************************************
   // Request routing
   // ********************************************************************
   assign altEn = routingReg[`RT_ALT_EN];
   assign altFf = routingReg[`RT_ALT_FF];
   assign dstMode = addr_mode_t'(modeReg[`MD_DST_LSB +: 2]);
   assign srcMode = addr_mode_t'(modeReg[`MD_SRC_LSB +: 2]);
   assign ch1Mode = waitCtlReg[`WC_CH1_MODE_LSB +: 2];
   // Source select of channel 0 follows the destination pointer for memory-to-I/O, else source.
   assign ch0Sel = (dstMode == ADDR_IO) ? dstReg[17:16] : srcReg[17:16];

   always_comb
   begin
      // [RULE17] channel 0 source
      case (ch0Sel)
         2'b00: ch0Raw = ext0Req;
         2'b01: ch0Raw = (dstMode == ADDR_IO) ? serial0TxReq : serial0RxReq;
         2'b10: ch0Raw = (dstMode == ADDR_IO) ? serial1TxReq : serial1RxReq;
         default: ch0Raw = ext1Req;
      endcase
      // [RULE8] [RULE9] channel 1 source
      case (routingReg[2:0])
         3'b000: ch1Raw = ext1Req;
         3'b001: ch1Raw = waitCtlReg[`WC_DIR1] ? serial0RxReq : serial0TxReq;
         3'b010: ch1Raw = waitCtlReg[`WC_DIR1] ? serial1RxReq : serial1TxReq;
         3'b011: ch1Raw = ext0Req;
         default: ch1Raw = 1'b0;
      endcase
   end

   assign sameSource = ch0Raw == ch1Raw;

   // [RULE1] [RULE2] [RULE6] alternation gating
   // [RULE5] forced onto channel 1
   // A differing source set still moves channel 0's request to channel 1 while the flop is set.
   assign chan0Req = altEn ? (!altFf && ch0Raw) : ch0Raw;
   assign chan1Req = altEn ? (altFf && (sameSource ? ch1Raw : ch0Raw)) : ch1Raw;

   // ********************************************************************
   // Mode decode
   // ********************************************************************
   // [RULE13] steal or burst
   assign chan0Burst = modeReg[`MD_BURST];
   // [RULE11] [RULE12] I/O ends
   assign chan0SrcIo = (srcMode == ADDR_IO);
   assign chan0DstIo = (dstMode == ADDR_IO);
   // [RULE14] channel 1 direction
   assign chan1IoToMem = ch1Mode[1];

   wait_gen waits
   (
      .clk(clk),
      .srst(srst),
      .clkEn(clkEn),
      .start(busCycleStart),
      .ioCycle(busCycleIo),
      .memWait(waitCtlReg[`WC_MWAIT_LSB +: 2]),
      .ioWait(waitCtlReg[`WC_IWAIT_LSB +: 2]),
      .waitActive(waitActive)
   );

   // ********************************************************************
   // Registers and address stepping
   // ********************************************************************
   function automatic logic [`ADDR_W-1:0] stepAddr(input logic [`ADDR_W-1:0] a,
                                                   input addr_mode_t m);
      case (m)
         ADDR_INC: stepAddr = a + `ADDR_W'(1);
         ADDR_DEC: stepAddr = a - `ADDR_W'(1);
         default: stepAddr = a;
      endcase
   endfunction : stepAddr

   always_comb
   begin
      routingNext = routingReg;
      modeNext = modeReg;
      waitCtlNext = waitCtlReg;
      srcNext = srcReg;
      dstNext = dstReg;
      mem1Next = mem1Reg;
      rdataNext = 8'h00;
      // [RULE19] byte stepping
      if (chan0ByteDone)
      begin
         srcNext = stepAddr(srcReg, srcMode);
         dstNext = stepAddr(dstReg, dstMode);
      end
      if (chan1ByteDone)
      begin
         mem1Next = stepAddr(mem1Reg, ch1Mode[0] ? ADDR_DEC : ADDR_INC);
      end
      if (regWr)
      begin
         case (regAddr)
            `OFS_ROUTING: routingNext = {regWdata[7:6], 3'b000, regWdata[2:0]};
            `OFS_MODE: modeNext = {2'b00, regWdata[5:1], 1'b0};
            `OFS_WAITCTL: waitCtlNext = regWdata;
            `OFS_SRC_LO: srcNext[7:0] = regWdata;
            `OFS_SRC_MID: srcNext[15:8] = regWdata;
            `OFS_SRC_HI: srcNext[19:16] = regWdata[3:0];
            `OFS_DST_LO: dstNext[7:0] = regWdata;
            `OFS_DST_MID: dstNext[15:8] = regWdata;
            `OFS_DST_HI: dstNext[19:16] = regWdata[3:0];
            `OFS_MEM1_LO: mem1Next[7:0] = regWdata;
            `OFS_MEM1_MID: mem1Next[15:8] = regWdata;
            `OFS_MEM1_HI: mem1Next[19:16] = regWdata[3:0];
            default: ;
         endcase
      end
      // [RULE1] [RULE2] [RULE6] flip-flop toggling
      // Channel ends are applied after a software write so hardware events are never lost.
      if (routingNext[`RT_ALT_EN])
      begin
         if (chan0TransferEnd && !chan1TransferEnd)
         begin
            routingNext[`RT_ALT_FF] = 1'b1;
         end
         else if (chan1TransferEnd && !chan0TransferEnd)
         begin
            routingNext[`RT_ALT_FF] = 1'b0;
         end
         else if (chan0TransferEnd && chan1TransferEnd)
         begin
            routingNext[`RT_ALT_FF] = !routingReg[`RT_ALT_FF];
         end
      end
      if (regRd)
      begin
         case (regAddr)
            `OFS_ROUTING: rdataNext = routingReg;
            `OFS_MODE: rdataNext = modeReg;
            `OFS_WAITCTL: rdataNext = waitCtlReg;
            `OFS_SRC_LO: rdataNext = srcReg[7:0];
            `OFS_SRC_MID: rdataNext = srcReg[15:8];
            `OFS_SRC_HI: rdataNext = {4'h0, srcReg[19:16]};
            `OFS_DST_LO: rdataNext = dstReg[7:0];
            `OFS_DST_MID: rdataNext = dstReg[15:8];
            `OFS_DST_HI: rdataNext = {4'h0, dstReg[19:16]};
            `OFS_MEM1_LO: rdataNext = mem1Reg[7:0];
            `OFS_MEM1_MID: rdataNext = mem1Reg[15:8];
            `OFS_MEM1_HI: rdataNext = {4'h0, mem1Reg[19:16]};
            `OFS_STATUS: rdataNext = {4'h0, waitActive, ext0Req, chan1Req, chan0Req};
            default: rdataNext = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         // [RULE3] alternation off
         routingReg <= `RST_ROUTING;
         modeReg <= `RST_MODE;
         waitCtlReg <= `RST_WAITCTL;
         srcReg <= '0;
         dstReg <= '0;
         mem1Reg <= '0;
         rdataReg <= 8'h00;
      end
      else if (clkEn)
      begin
         routingReg <= routingNext;
         modeReg <= modeNext;
         waitCtlReg <= waitCtlNext;
         srcReg <= srcNext;
         dstReg <= dstNext;
         mem1Reg <= mem1Next;
         rdataReg <= rdataNext;
      end
   end

   assign regRdata = rdataReg;
   assign chan0SourcePointer = srcReg;
   assign chan0DestPointer = dstReg;
   assign chan1MemoryPointer = mem1Reg;

endmodule : dma_req_mode_ctl

// file: tb/dma_req_mode_ctl_checker.sv
// Port checker for the DMA request and mode control, bound to its top module.
// Assumes clkEn never drops during a bus cycle and no routing write lands mid wait.
`include "dma_ctl_cfg.svh"

module dma_req_mode_ctl_checker
   import dma_ctl_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   input wire logic clkEn,
   // Register port
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regRdata,
   // Requesters and bus cycles
   input wire logic externalRequestLine1N,
   input wire logic sharedClockRequestLine0N,
   input wire logic serial0TxReq,
   input wire logic serial1RxReq,
   input wire logic busCycleStart,
   input wire logic busCycleIo,
   // Observed outputs
   input wire logic chan1Req,
   input wire logic waitActive
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] rtReg, rtNext, wcReg, wcNext;

   // ********************************************************************
   // Shadow registers and assertions
   // ********************************************************************
   // The shadows miss hardware toggles of bit 6, so routing checks run with alternation off.
   always_comb
   begin
      rtNext = rtReg;
      wcNext = wcReg;
      if (regWr && clkEn && regAddr == `OFS_ROUTING)
         rtNext = regWdata;
      if (regWr && clkEn && regAddr == `OFS_WAITCTL)
         wcNext = regWdata;
   end

   always_ff @(posedge clk)
   begin
      rtReg <= srst ? `RST_ROUTING : rtNext;
      wcReg <= srst ? `RST_WAITCTL : wcNext;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   property p_alt_off;
      regRd && clkEn && regAddr == `OFS_ROUTING && !rtReg[7] |=> regRdata[7] == 1'b0;
   endproperty
   a_alt_off: assert property (p_alt_off) else $error("alternation bit read high");
   property p_line1;
      rtReg[7:6] == 2'h0 && rtReg[2:0] == 3'h0 && !wcReg[`WC_SENSE1]
         |-> chan1Req == !externalRequestLine1N;
   endproperty
   a_line1: assert property (p_line1) else $error("line 1 not routed");
   property p_ser0tx;
      rtReg[7:6] == 2'h0 && rtReg[2:0] == 3'h1 && !wcReg[1] |-> chan1Req == serial0TxReq;
   endproperty
   a_ser0tx: assert property (p_ser0tx) else $error("serial 0 send not routed");
   property p_ser1rx;
      rtReg[7:6] == 2'h0 && rtReg[2:0] == 3'h2 && wcReg[1] |-> chan1Req == serial1RxReq;
   endproperty
   a_ser1rx: assert property (p_ser1rx) else $error("serial 1 receive not routed");
   property p_line0;
      rtReg[7:6] == 2'h0 && rtReg[2:0] == 3'h3 && !wcReg[`WC_SENSE0]
         |-> chan1Req == !sharedClockRequestLine0N;
   endproperty
   a_line0: assert property (p_line0) else $error("line 0 not routed");
   property p_mem0;
      busCycleStart && !busCycleIo && wcReg[7:6] == 2'h0 |=> !waitActive [*3];
   endproperty
   a_mem0: assert property (p_mem0) else $error("wait added to zero-wait cycle");
   property p_mem2;
      busCycleStart && !busCycleIo && wcReg[7:6] == 2'h2 |=> waitActive [*2] ##1 !waitActive;
   endproperty
   a_mem2: assert property (p_mem2) else $error("memory wait count wrong");
   property p_io1;
      busCycleStart && busCycleIo && wcReg[5:4] == 2'h0 |=> waitActive ##1 !waitActive;
   endproperty
   a_io1: assert property (p_io1) else $error("minimum I/O wait wrong");
   property p_io4;
      busCycleStart && busCycleIo && wcReg[5:4] == 2'h3 |=> waitActive [*4] ##1 !waitActive;
   endproperty
   a_io4: assert property (p_io4) else $error("maximum I/O wait wrong");
endmodule : dma_req_mode_ctl_checker

bind dma_req_mode_ctl dma_req_mode_ctl_checker i_checker (.clk(clk), .srst(srst), .clkEn(clkEn),
   .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
   .externalRequestLine1N(externalRequestLine1N),
   .sharedClockRequestLine0N(sharedClockRequestLine0N), .serial0TxReq(serial0TxReq),
   .serial1RxReq(serial1RxReq), .busCycleStart(busCycleStart), .busCycleIo(busCycleIo),
   .chan1Req(chan1Req), .waitActive(waitActive));

// file: tb/req_model.sv
// Model of the requesters: the two request pins and the serial channels.
// Assumes want holds one bit a requester: line 1, ser0 tx, ser1 tx, line 0, ser0 rx, ser1 rx.
module req_model
(
   // Clock and wanted requests
   input wire logic clk,
   input wire logic [5:0] want,
   // Request lines
   output logic externalRequestLine1N,
   output logic sharedClockRequestLine0N,
   output logic serial0TxReq,
   output logic serial0RxReq,
   output logic serial1TxReq,
   output logic serial1RxReq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [5:0] held = 6'h00;

   // The pins follow one edge late, as a slow requester would.
   always @(posedge clk)
      held <= want;

   assign externalRequestLine1N = ~held[0];
   assign serial0TxReq = held[1];
   assign serial1TxReq = held[2];
   assign sharedClockRequestLine0N = ~held[3];
   assign serial0RxReq = held[4];
   assign serial1RxReq = held[5];
endmodule : req_model

// file: tb/dma_req_mode_ctl_tb.sv
// Self-checking bench of the DMA request and mode control.
// Assumes the checker binds itself; clkEn drops only in the freeze check of the mode scenario.
`include "dma_ctl_cfg.svh"

module dma_req_mode_ctl_tb
   import dma_ctl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, srst = 1'b1, clkEn = 1'b1, regWr = 1'b0, regRd = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWdata = 8'h00, regRdata;
   logic [5:0] want = 6'h00;
   logic line1N, line0N, s0Tx, s0Rx, s1Tx, s1Rx, end0 = 1'b0, end1 = 1'b0, done = 1'b0;
   logic busStart = 1'b0, busIo = 1'b0, c0Req, c1Req, burst, srcIo, dstIo, ioToMem, waitOn;
   logic [19:0] srcPtr, dstPtr, memPtr;
   int miscompares = 0, cmp_count = 0;

   always #50 clk = ~clk;

   req_model i_req (.clk(clk), .want(want), .externalRequestLine1N(line1N),
      .sharedClockRequestLine0N(line0N), .serial0TxReq(s0Tx), .serial0RxReq(s0Rx),
      .serial1TxReq(s1Tx), .serial1RxReq(s1Rx));
   dma_req_mode_ctl i_dut (.clk(clk), .srst(srst), .clkEn(clkEn), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .externalRequestLine1N(line1N), .sharedClockRequestLine0N(line0N),
      .serial0TxReq(s0Tx), .serial0RxReq(s0Rx), .serial1TxReq(s1Tx), .serial1RxReq(s1Rx),
      .chan0TransferEnd(end0), .chan1TransferEnd(end1), .chan0ByteDone(done),
      .chan1ByteDone(done), .busCycleStart(busStart), .busCycleIo(busIo), .chan0Req(c0Req),
      .chan1Req(c1Req), .chan0Burst(burst), .chan0SrcIo(srcIo), .chan0DstIo(dstIo),
      .chan1IoToMem(ioToMem), .waitActive(waitOn), .chan0SourcePointer(srcPtr),
      .chan0DestPointer(dstPtr), .chan1MemoryPointer(memPtr));

   // ********************************************************************
   // Helpers: every task starts and ends at a falling edge
   // ********************************************************************
   task automatic check(input string what, input logic [19:0] seen, input logic [19:0] expd);
      cmp_count++;
      if (seen !== expd)
      begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, expd, seen);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : tick

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      @(negedge clk);
   endtask : wr

   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      @(negedge clk);
      check("read data", 20'(regRdata), 20'(e));
   endtask : rdc

   task automatic req(input logic [5:0] v);
      @(posedge clk);
      want <= v;
      tick(3);
   endtask : req

   task automatic pulse(input int kind);
      @(posedge clk);
      end0 <= (kind == 0);
      end1 <= (kind == 1);
      done <= (kind == 2);
      @(posedge clk);
      {end0, end1, done} <= 3'h0;
      @(negedge clk);
   endtask : pulse

   // ********************************************************************
   // Scenarios
   // ********************************************************************
   task automatic t_reset;
      rdc(`OFS_ROUTING, 8'h00);
      rdc(`OFS_WAITCTL, 8'hf0);
      rdc(4'hd, 8'h00);
   endtask : t_reset

   task automatic t_routing;
      logic [5:0] pick;
      for (int dir = 0; dir < 2; dir++)
         for (int code = 0; code < 4; code++)
         begin
            wr(`OFS_ROUTING, 8'(code));
            wr(`OFS_WAITCTL, 8'(dir << `WC_DIR1));
            pick = 6'h1 << (code == 0 ? 0 : code == 3 ? 3 : code + 3 * dir);
            req(pick);
            check("routed request", 20'(c1Req), 20'h1);
            req(~pick);
            check("other requests", 20'(c1Req), 20'h0);
         end
      wr(`OFS_ROUTING, 8'h00);
      req(6'h00);
      wr(`OFS_WAITCTL, 8'h08);
      req(6'h01);
      req(6'h00);
      check("edge held", 20'(c1Req), 20'h1);
      pulse(2);
      check("edge taken", 20'(c1Req), 20'h0);
   endtask : t_routing

   task automatic t_modes;
      wr(`OFS_MODE, 8'h3e);
      wr(`OFS_WAITCTL, 8'h02);
      check("modes", 20'({dstIo, srcIo, burst, ioToMem}), 20'hf);
      wr(`OFS_MODE, 8'h00);
      wr(`OFS_WAITCTL, 8'h01);
      check("modes", 20'({dstIo, srcIo, burst, ioToMem}), 20'h0);
      // A write while the clock enable is low must not land.
      @(posedge clk);
      clkEn <= 1'b0;
      wr(`OFS_MODE, 8'h02);
      @(posedge clk);
      clkEn <= 1'b1;
      tick(0);
      check("frozen mode", 20'(burst), 20'h0);
   endtask : t_modes

   task automatic wptr(input logic [3:0] base, input logic [19:0] v);
      wr(base, v[7:0]);
      wr(base + 4'h1, v[15:8]);
      wr(base + 4'h2, {4'h0, v[19:16]});
   endtask : wptr

   task automatic t_pointers;
      wptr(`OFS_SRC_LO, 20'h00100);
      wptr(`OFS_DST_LO, 20'h0ffff);
      wptr(`OFS_MEM1_LO, 20'h00000);
      wr(`OFS_MODE, 8'h04);
      pulse(2);
      check("source", srcPtr, 20'h000ff);
      check("dest", dstPtr, 20'h10000);
      check("chan1 memory", memPtr, 20'hfffff);
      wr(`OFS_MODE, 8'h28);
      pulse(2);
      check("fixed source", srcPtr, 20'h000ff);
      check("fixed dest", dstPtr, 20'h10000);
   endtask : t_pointers

   task automatic t_wait;
      int n;
      for (int io = 0; io < 2; io++)
         for (int c = 0; c < 4; c++)
         begin
            // memory wait also exercised at zero
            wr(`OFS_WAITCTL, 8'((c << 6) | (c << 4)));
            @(posedge clk);
            busIo <= 1'(io);
            busStart <= 1'b1;
            @(posedge clk);
            busStart <= 1'b0;
            n = 0;
            repeat (8)
            begin
               @(negedge clk);
               n += int'(waitOn === 1'b1);
            end
            check("wait states", 20'(n), 20'(c + io));
         end
   endtask : t_wait

   task automatic t_alt;
      wptr(`OFS_SRC_LO, 20'h10000);
      wr(`OFS_MODE, 8'h00);
      wr(`OFS_WAITCTL, 8'h02);
      // both channels share serial 0 receive
      wr(`OFS_ROUTING, 8'h81);
      req(6'h10);
      check("owner", 20'({c0Req, c1Req}), 20'h2);
      rdc(`OFS_STATUS, 8'h01);
      pulse(0);
      check("owner", 20'({c0Req, c1Req}), 20'h1);
      rdc(`OFS_ROUTING, 8'hc1);
      pulse(1);
      check("owner", 20'({c0Req, c1Req}), 20'h2);
      rdc(`OFS_ROUTING, 8'h81);
      wr(`OFS_ROUTING, 8'h80);
      pulse(0);
      check("forced", 20'(c1Req), 20'h1);
      pulse(1);
      wr(`OFS_ROUTING, 8'h00);
   endtask : t_alt

   task automatic print_verdict;
      $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : print_verdict

   initial
   begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      @(negedge clk);
      t_reset();
      t_routing();
      t_modes();
      t_pointers();
      t_wait();
      t_alt();
      print_verdict();
   end

   // A hang is cut short here and counted as a mismatch.
   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      print_verdict();
   end
endmodule : dma_req_mode_ctl_tb
